// ===== rtl/roi_consts.svh
// Constants for the robot operation interlock block.
`ifndef ROI_CONSTS_SVH
`define ROI_CONSTS_SVH
`define ROI_AXES 8
`define ROI_CLK_HZ 25000000
`define ROI_KEY_RESP_MS 15
`define ROI_KEY_SETTLE_CYC ((`ROI_KEY_RESP_MS * `ROI_CLK_HZ) / 1000)
`define ROI_MODE_RESET 1'b0
`endif

// ===== rtl/roi_pkg.sv
// Types shared by the robot operation interlock block.
`default_nettype none
package roi_pkg;
  typedef enum logic {
    ROI_MANUAL,
    ROI_AUTO
  } roi_mode_type;
  typedef struct packed {
    logic pendant_enabled;
    logic pendant_switch;
    logic enabling_closed;
    logic door_closed;
  } roi_switch_type;
  typedef struct packed {
    logic servo_on_req;
    logic jog_req;
    logic brake_req;
    logic auto_start_req;
  } roi_request_type;
endpackage
`default_nettype wire

// ===== rtl/roi_interlock.sv
// Operation permission and safety interlock logic of a robot controller.
`timescale 1ns/1ps
`default_nettype none
`include "roi_consts.svh"
// Behaviour
// - Door open: servo on only with pendant switch and enabling device both held.
// - Door open: releasing the enabling device alone drops servo power.
// - Door open, enabling released: refuse servo-on and brake release requests.
// - Door closed: servo on through pendant alone.
// - Jog: manual, pendant enabled, switch on, enabling closed or door closed.
// - Jog with enabling open additionally needs the door closed.
// - Brake release: manual, pendant enabled, switch on, enabling closed; door ignored.
// - Automatic run: auto mode, pendant disabled, door closed always.
// - Extra axis contactor output follows robot servo state.
// - Servo on commanded to all AXES axes together (eight by default).
// - Automatic right: accept external operation, reject pendant operation.
// - Manual right with pendant: accept pendant only, reject external.
// - Both key lines open manual, both closed auto, otherwise hold.
// - Door opened in automatic run: servo off, stop, latched error until reset.
// - Mode contact open in manual, closed in automatic.
module roi_interlock #(
  parameter int AXES = `ROI_AXES,
  parameter int KEY_SETTLE_CYC = `ROI_KEY_SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic mode_key_line1_input,
  input wire logic mode_key_line2_input,
  input wire roi_pkg::roi_switch_type switch_pins,
  input wire roi_pkg::roi_request_type pendant_req,
  input wire roi_pkg::roi_request_type external_req,
  input wire logic alarm_reset,
  output logic [AXES-1:0] axis_servo_on,
  output logic servo_on,
  output logic jog_permit,
  output logic brake_release,
  output logic auto_running,
  output logic door_error,
  output logic extra_axis_contactor_output,
  output logic mode_contact_out,
  output logic ext_req_rejected,
  output logic pendant_req_rejected
);
  // Refuse sizes that the replicated axis bus or the settle counter cannot serve.
  if (AXES < 1 || AXES > 8) begin : g_bad_axes
    $error("AXES must lie between 1 and 8");
  end
  if (KEY_SETTLE_CYC < 1) begin : g_bad_settle
    $error("KEY_SETTLE_CYC must be at least 1");
  end

  localparam int CW = $clog2(KEY_SETTLE_CYC + 1);

  // Two-flop synchronisers for the two key lines and four switch pins; stage one is read only by stage two.
  logic [5:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  always_comb begin
    pin_s1_d = {mode_key_line1_input, mode_key_line2_input, switch_pins};
    pin_s2_d = pin_s1_q;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
    end else if (clk_en) begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  logic key1, key2;
  roi_pkg::roi_switch_type sw;
  assign key1 = pin_s2_q[5];
  assign key2 = pin_s2_q[4];
  assign sw = roi_pkg::roi_switch_type'(pin_s2_q[3:0]);

  // Key lines must agree for the settle time before the mode changes; this
  // filters contact bounce at the cost of a short delay in the mode swap.
  roi_pkg::roi_mode_type mode_q, mode_d;
  logic [CW-1:0] settle_q, settle_d;
  logic key_agree, key_target;
  assign key_agree = (key1 == key2);
  assign key_target = key1;
  always_comb begin
    mode_d = mode_q;
    settle_d = settle_q;
    if (!key_agree || (key_target == (mode_q == roi_pkg::ROI_AUTO))) begin
      settle_d = '0;
    end else if (settle_q == CW'(KEY_SETTLE_CYC - 1)) begin
      settle_d = '0;
      mode_d = key_target ? roi_pkg::ROI_AUTO : roi_pkg::ROI_MANUAL;
    end else begin
      settle_d = settle_q + CW'(1);
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= roi_pkg::roi_mode_type'(`ROI_MODE_RESET); // Manual right after reset.
      settle_q <= '0;
    end else if (clk_en) begin
      mode_q <= mode_d;
      settle_q <= settle_d;
    end
  end

  logic manual, auto_mode, pendant_ok;
  assign manual = (mode_q == roi_pkg::ROI_MANUAL);
  assign auto_mode = (mode_q == roi_pkg::ROI_AUTO);
  assign pendant_ok = sw.pendant_enabled && sw.pendant_switch;

  // Operating right selects which request source is heard.
  roi_pkg::roi_request_type req;
  always_comb begin
    req = auto_mode ? external_req : pendant_req;
    if (auto_mode) begin
      req.jog_req = 1'b0;
      req.brake_req = 1'b0;
      req.servo_on_req = external_req.servo_on_req && !sw.pendant_enabled;
    end else begin
      req.auto_start_req = 1'b0;
      req.servo_on_req = pendant_req.servo_on_req && sw.pendant_enabled;
    end
  end

  // Standing conditions, evaluated every cycle so any loss drops power at once.
  logic teach_cond, auto_cond, jog_cond, brake_cond;
  always_comb begin
    // Teach and jog: door open needs both switches; door closed needs the pendant only; brake always needs both.
    teach_cond = manual && pendant_ok && (sw.enabling_closed || sw.door_closed);
    jog_cond = teach_cond;
    brake_cond = manual && pendant_ok && sw.enabling_closed;
    auto_cond = auto_mode && !sw.pendant_enabled && sw.door_closed;
  end

  // Servo and run state with the latched door error.
  logic servo_q, servo_d, run_q, run_d, err_q, err_d;
  always_comb begin
    servo_d = servo_q;
    run_d = run_q;
    err_d = err_q;
    if (alarm_reset && sw.door_closed) begin
      err_d = 1'b0;
    end
    if (run_q && !sw.door_closed) begin
      err_d = 1'b1;
    end
    if (manual) begin
      run_d = 1'b0;
      // A latched door error also keeps teaching servo off until the alarm is reset.
      if (!teach_cond || err_d) begin
        servo_d = 1'b0;
      end else if (req.servo_on_req) begin
        servo_d = 1'b1;
      end
    end else begin
      if (!auto_cond || err_d) begin
        servo_d = 1'b0;
        run_d = 1'b0;
      end else begin
        if (req.servo_on_req) begin
          servo_d = 1'b1;
        end
        if (req.auto_start_req && servo_q) begin
          run_d = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      servo_q <= 1'b0;
      run_q <= 1'b0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      servo_q <= servo_d;
      run_q <= run_d;
      err_q <= err_d;
    end
  end

  // Registered outputs; motion grants are gated by live conditions as well.
  logic jog_q, jog_d, brake_q, brake_d, rej_e_q, rej_e_d, rej_p_q, rej_p_d;
  always_comb begin
    jog_d = jog_cond && servo_d && req.jog_req;
    brake_d = brake_cond && req.brake_req;
    rej_e_d = manual && (|external_req);
    rej_p_d = auto_mode && (pendant_req.jog_req || pendant_req.brake_req ||
                            pendant_req.servo_on_req);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      jog_q <= 1'b0;
      brake_q <= 1'b0;
      rej_e_q <= 1'b0;
      rej_p_q <= 1'b0;
    end else if (clk_en) begin
      jog_q <= jog_d;
      brake_q <= brake_d;
      rej_e_q <= rej_e_d;
      rej_p_q <= rej_p_d;
    end
  end

  assign servo_on = servo_q;
  assign axis_servo_on = {AXES{servo_q}};
  assign extra_axis_contactor_output = servo_q;
  assign mode_contact_out = auto_mode;
  assign jog_permit = jog_q;
  assign brake_release = brake_q;
  assign auto_running = run_q;
  assign door_error = err_q;
  assign ext_req_rejected = rej_e_q;
  assign pendant_req_rejected = rej_p_q;

  // Safety invariants; they read the synchronised switches, so pins count two cycles late.
  // Attempts of the |=> checks other than chk_err_holds start on an enabled cycle only, since a frozen block must hold its state.
  chk_door_open_servo: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual && !sw.door_closed && !(sw.enabling_closed && pendant_ok)) |=> !servo_q)
    else $error("servo on with door open and switches not both held");
  chk_brake_needs_enable: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !sw.enabling_closed) |=> !brake_q)
    else $error("brake released without enabling device");
  chk_auto_needs_door: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !sw.door_closed) |=> !run_q)
    else $error("automatic run with door open");
  chk_door_err_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && run_q && !sw.door_closed) |=> (err_q && !servo_q))
    else $error("door opening in automatic run did not latch error");
  chk_err_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (err_q && !alarm_reset) |=> err_q)
    else $error("door error cleared without alarm reset");
  chk_contactor_follow: assert property (@(posedge sys_clk) disable iff (rst)
    extra_axis_contactor_output == servo_on && axis_servo_on == {AXES{servo_on}})
    else $error("contactor or axes disagree with robot servo");
  chk_mode_contact: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(mode_contact_out) |-> $past(settle_q) == CW'(KEY_SETTLE_CYC - 1))
    else $error("mode changed without settled key lines");
  chk_mode_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !key_agree) |=> $stable(mode_q))
    else $error("mode changed while key lines disagree");
  chk_jog_manual: assert property (@(posedge sys_clk) disable iff (rst)
    jog_q |-> $past(manual))
    else $error("jog granted outside manual right");

  // Positive grants: a legal request must be honoured on the next cycle.
  chk_servo_grant: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual && pendant_ok && sw.door_closed && pendant_req.servo_on_req && !err_q && !run_q)
    |=> servo_on)
    else $error("servo refused with door closed and pendant ready");
  chk_jog_door_open: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual && pendant_ok && sw.enabling_closed && !sw.door_closed && !err_q && !run_q &&
     pendant_req.servo_on_req && pendant_req.jog_req) |=> jog_permit)
    else $error("jog refused with enabling device held");
  chk_brake_grant: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual && pendant_ok && sw.enabling_closed && pendant_req.brake_req) |=> brake_release)
    else $error("brake release refused with both switches held");

  // Refusals: a missing condition must block the grant on the next cycle.
  chk_jog_drop: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !sw.door_closed && !sw.enabling_closed) |=> !jog_permit)
    else $error("jog granted with door and enabling device both open");
  chk_enable_release: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && !sw.door_closed && !sw.enabling_closed) |=> (!servo_on && !brake_release))
    else $error("servo or brake allowed with door open and enabling released");
  chk_pendant_blocks_run: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && sw.pendant_enabled) |=> !auto_running)
    else $error("automatic run with pendant enabled");
  chk_manual_no_run: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual) |=> !auto_running)
    else $error("automatic run under manual right");
  chk_run_needs_servo: assert property (@(posedge sys_clk) disable iff (rst)
    auto_running |-> servo_on)
    else $error("automatic run without servo power");
  chk_err_blocks_servo: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && err_q && !alarm_reset) |=> !servo_on)
    else $error("servo on while door error is latched");

  // Operating right: the unheard source is flagged one cycle after it asks, except a pendant auto start request.
  chk_pendant_reject: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && auto_mode && (pendant_req.servo_on_req || pendant_req.jog_req || pendant_req.brake_req))
    |=> pendant_req_rejected)
    else $error("pendant request not rejected under automatic right");
  chk_ext_reject: assert property (@(posedge sys_clk) disable iff (rst)
    (clk_en && manual && (|external_req)) |=> ext_req_rejected)
    else $error("external request not rejected under manual right");

  // Every axis carries the robot servo state, never a partial set.
  chk_axes_count: assert property (@(posedge sys_clk) disable iff (rst)
    $countones(axis_servo_on) == (servo_on ? AXES : 0))
    else $error("axis servo count disagrees with robot servo");

  // Door opening in automatic run: the trigger, then the stopped and latched outcome.
  sequence s_run_door_open;
    clk_en && auto_mode && run_q && !sw.door_closed;
  endsequence
  sequence s_stopped_latched;
    err_q && !servo_q && !run_q;
  endsequence
  chk_door_stop: assert property (@(posedge sys_clk) disable iff (rst)
    s_run_door_open |=> s_stopped_latched)
    else $error("door opening in automatic run did not stop the robot");
endmodule
`default_nettype wire

// ===== testbench/roi_switch_model.sv
// Model of the operator switches, pendant and door in front of the interlock.
`timescale 1ns/1ps
`default_nettype none
module roi_switch_model (
  input wire logic pendant_on,
  input wire logic pendant_grip,
  input wire logic enabler_grip,
  input wire logic door_shut,
  input wire logic contactor,
  output var roi_pkg::roi_switch_type switch_pins,
  output logic amp_power
);
  // A grip closes only in the light middle position, one operator on each switch.
  always_comb begin
    switch_pins.pendant_enabled = pendant_on;
    switch_pins.pendant_switch = pendant_grip;
    switch_pins.enabling_closed = enabler_grip;
    switch_pins.door_closed = door_shut;
  end
  // An arm-linked axis amplifier is powered only through the closed contactor;
  // an independent mechanism would leave the contactor unconnected instead.
  assign amp_power = contactor;
endmodule
`default_nettype wire

// ===== testbench/robot_operation_interlock_tb.sv
// Self-checking testbench of the robot operation interlock.
`timescale 1ns/1ps
`default_nettype none
module robot_operation_interlock_tb;
  logic sys_clk, rst, k1, k2, p_on, p_grip, e_grip, door, alarm_reset;
  logic ce, amp;
  roi_pkg::roi_switch_type pins;
  roi_pkg::roi_request_type p_req, x_req;
  logic [7:0] axes;
  logic servo, jog, brake, run, derr, cont, mode, x_rej, p_rej;
  int miscompares = 0;
  int n_compared = 0;
  roi_switch_model u_model (.pendant_on(p_on), .pendant_grip(p_grip), .enabler_grip(e_grip),
    .door_shut(door), .contactor(cont), .switch_pins(pins), .amp_power(amp));
  // Short key settle count keeps the mode tests brief.
  roi_interlock #(.AXES(8), .KEY_SETTLE_CYC(4)) u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(ce),
    .mode_key_line1_input(k1), .mode_key_line2_input(k2), .switch_pins(pins), .pendant_req(p_req),
    .external_req(x_req), .alarm_reset(alarm_reset), .axis_servo_on(axes), .servo_on(servo),
    .jog_permit(jog), .brake_release(brake), .auto_running(run), .door_error(derr),
    .extra_axis_contactor_output(cont), .mode_contact_out(mode), .ext_req_rejected(x_rej),
    .pendant_req_rejected(p_rej));
  // Free running 25 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Compares one value and counts it.
  task automatic check(input string name, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Pins pass a two stage synchroniser, so four cycles cover any pin change.
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Sets both key lines and waits, bounded, for the mode contact.
  task automatic set_mode(input logic a, input logic b, input logic exp);
    k1 = a;
    k2 = b;
    for (int i = 0; i < 20 && mode !== exp; i++) step(1);
    check("mode", mode, exp);
    if (mode !== exp) end_of_test();
  endtask
  // Door closed: pendant alone gives servo; opening the door drops it.
  task automatic t_door_closed();
    {p_on, p_grip, e_grip, door} = 4'hD;
    p_req.servo_on_req = 1'b1;
    step(4);
    check("servo", servo, 1'b1);
    check("contactor", cont, 1'b1);
    check("amp power", amp, 1'b1);
    check("all axes", &axes, 1'b1);
    p_req.jog_req = 1'b1;
    step(2);
    check("jog", jog, 1'b1);
    door = 1'b0;
    step(4);
    check("jog", jog, 1'b0);
    check("servo", servo, 1'b0);
    check("contactor", cont, 1'b0);
    check("any axis", |axes, 1'b0);
    p_req = '0;
    step(2);
  endtask
  // Door open: both grips needed, enabler release cuts everything.
  task automatic t_door_open();
    {p_on, p_grip, e_grip, door} = 4'hE;
    p_req = 4'hE;
    step(4);
    check("servo", servo, 1'b1);
    check("jog", jog, 1'b1);
    check("brake", brake, 1'b1);
    x_req.servo_on_req = 1'b1;
    step(2);
    check("ext rejected", x_rej, 1'b1);
    e_grip = 1'b0;
    step(4);
    check("servo", servo, 1'b0);
    check("brake", brake, 1'b0);
    {e_grip, p_grip} = 2'h2;
    step(4);
    check("servo", servo, 1'b0);
    check("brake", brake, 1'b0);
    p_req = '0;
    x_req = '0;
    step(4);
  endtask
  // Automatic right, run, door error and its alarm reset.
  task automatic t_auto();
    k1 = 1'b1;
    step(20);
    check("mode held", mode, 1'b0);
    set_mode(1'b1, 1'b1, 1'b1);
    {p_on, p_grip, e_grip, door} = 4'h1;
    p_req.jog_req = 1'b1;
    step(4);
    check("pendant rejected", p_rej, 1'b1);
    p_req = '0;
    x_req.servo_on_req = 1'b1;
    step(2);
    check("servo", servo, 1'b1);
    x_req.auto_start_req = 1'b1;
    step(2);
    check("run", run, 1'b1);
    door = 1'b0;
    alarm_reset = 1'b1;
    step(4);
    check("door error", derr, 1'b1);
    check("servo", servo, 1'b0);
    check("run", run, 1'b0);
    door = 1'b1;
    step(4);
    check("door error", derr, 1'b0);
    {alarm_reset, x_req} = '0;
    set_mode(1'b0, 1'b0, 1'b0);
  endtask
  // Clock enable low freezes all state; a mid-run reset clears and resynchronises the pins.
  task automatic t_freeze_reset();
    {p_on, p_grip, e_grip, door} = 4'hD;
    p_req.servo_on_req = 1'b1;
    step(4);
    check("servo", servo, 1'b1);
    ce = 1'b0;
    door = 1'b0;
    step(4);
    check("servo frozen", servo, 1'b1);
    ce = 1'b1;
    step(4);
    check("servo", servo, 1'b0);
    check("amp power", amp, 1'b0);
    door = 1'b1;
    step(4);
    check("servo", servo, 1'b1);
    rst = 1'b1;
    step(1);
    check("servo in reset", servo, 1'b0);
    check("contactor in reset", cont, 1'b0);
    rst = 1'b0;
    step(2);
    check("servo during pin sync", servo, 1'b0);
    step(2);
    check("servo after reset", servo, 1'b1);
    p_req = '0;
    step(2);
  endtask
  // Reset for three cycles, then every scenario in turn.
  initial begin
    {rst, k1, k2, p_on, p_grip, e_grip, door, alarm_reset} = 8'h82;
    p_req = '0;
    x_req = '0;
    ce = 1'b1;
    step(3);
    check("servo in reset", servo, 1'b0);
    check("mode in reset", mode, 1'b0);
    rst = 1'b0;
    step(4);
    t_door_closed();
    t_door_open();
    t_auto();
    t_freeze_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
